// ==== src/pasm_pkg.sv ====
package pasm_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0] OFS_PURE_ANALOG = 8'hAE;
  localparam logic [7:0] OFS_HIGH_REF = 8'hAF;
  localparam logic [7:0] OFS_MODE = 8'hB1;
  localparam logic [7:0] OFS_DIR = 8'hC4;
  localparam logic [7:0] OFS_DATA = 8'hD4;
  // ==========================================
  // Fields
  localparam int NPINS = 5;
  localparam int BIT_CONV_EN = 7;
  localparam int BIT_CONV_START = 6;
  localparam int BIT_EOC = 5;
  localparam int BIT_GCH_EN = 4;
  localparam int BIT_REF_EN = 7;
  localparam logic [7:0] MASK_MODE = 8'hF7;
  localparam logic [7:0] MASK_HIGH_REF = 8'h83;
  localparam logic [7:0] MASK_PIN = 8'h1F;
  localparam logic [7:0] RST_VAL = 8'h00;
  localparam logic [2:0] CH_MAX = 3'h5;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
endpackage : pasm_pkg

// ==== src/pasm_pin_cell.sv ====
`timescale 1ns/10ps
module pasm_pin_cell
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Pin control
  input wire logic pure_analog,
  input wire logic analog_sel,
  input wire logic ref_sel,
  input wire logic dir,
  input wire logic data,
  input wire logic pad_in,
  // Pin results
  output logic pad_out,
  output logic pad_oe,
  output logic analog_route,
  output logic ref_route,
  output logic din
);
  import pasm_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
    logic oe;
    logic ar;
    logic rr;
  } pasm_cell_s;
  pasm_cell_s st_r;
  pasm_cell_s st_nxt;
  logic digital_ok;

  always_comb
  begin
    st_nxt = st_r;
    // Digital path only when nothing analog owns the pin
    digital_ok = !pure_analog && !analog_sel && !ref_sel; // see R2 see R3 see R6 see R8
    st_nxt.s1 = pad_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.out = data;
    st_nxt.oe = digital_ok && dir; // see R11
    st_nxt.ar = analog_sel && !ref_sel; // see R8
    st_nxt.rr = ref_sel; // see R8
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0; // see R13
    else
      st_r <= st_nxt;
  end

  assign pad_out = st_r.out;
  assign pad_oe = st_r.oe;
  assign analog_route = st_r.ar;
  assign ref_route = st_r.rr;
  // Isolated input reads as zero
  assign din = st_r.s2 && !pure_analog && !ref_sel; // see R2 see R4
endmodule : pasm_pin_cell

// ==== src/pasm_top.sv ====
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
// Summary of operation
// R1 - At most one pin routed to converter
// R2 - Pure-analog bit isolates digital path
// R3 - Clear bit allows analog or digital
// R4 - Software keeps bit clear for digital
// R5 - Global enable off keeps pins digital; code still gives pin 0 to reference with converter and reference enables
// R6 - Global enable on: selected pin analog
// R7 - Selector 000..101 maps inputs 0..5
// R8 - Reference enable gives pin 0 reference
// R9 - Software clears reference before pin reuse
// R10 - Software writes data before direction
// R11 - Direction bit 1 output, 0 input
// R12 - Pin 0 analog needs enable, selector zero
// R13 - Reset leaves all pins digital inputs
module pasm_top
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic [pasm_pkg::NPINS-1:0] pin_in,
  output logic [pasm_pkg::NPINS-1:0] pin_out,
  output logic [pasm_pkg::NPINS-1:0] pin_oe,
  // Converter side
  output logic [pasm_pkg::NPINS-1:0] analog_route,
  output logic ext_high_ref_route,
  output logic [2:0] conv_channel,
  output logic conv_channel_valid,
  output logic converter_enable,
  output logic conversion_start,
  output logic [1:0] ref_select,
  // End of conversion from converter
  input wire logic conv_eoc_set
);
  import pasm_pkg::*;

  typedef struct packed {
    logic [4:0] port4_pure_analog_bits;
    logic [7:0] converter_mode_reg;
    logic [7:0] high_ref_config_reg;
    logic [4:0] port4_direction_bits;
    logic [4:0] data_latch;
    logic [7:0] rdata;
    logic [2:0] chan;
    logic chan_valid;
  } pasm_top_s;

  pasm_top_s st_r;
  pasm_top_s st_nxt;
  logic [NPINS-1:0] din;
  logic [NPINS-1:0] sel_pin;
  logic [NPINS-1:0] ref_pin;
  logic [NPINS-1:0] ref_flag;
  logic gch;
  logic [2:0] chs;

  // ==========================================
  // Channel decode
  always_comb
  begin
    gch = st_r.converter_mode_reg[BIT_CONV_EN] && st_r.converter_mode_reg[BIT_GCH_EN];
    chs = st_r.converter_mode_reg[2:0];
    sel_pin = '0;
    // One-hot select keeps a single pin routed; input 5 has no pin
    if (gch && chs < 3'(NPINS)) // see R1 see R5 see R6 see R12
      sel_pin[chs] = 1'b1; // see R7
    ref_pin = '0;
    ref_pin[0] = st_r.converter_mode_reg[BIT_CONV_EN]
      && st_r.high_ref_config_reg[BIT_REF_EN]; // see R8 see R9
  end

  // ==========================================
  // Register port
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = READ_UNMAPPED;
    if (reg_wr)
    begin
      if (reg_addr == OFS_PURE_ANALOG)
        st_nxt.port4_pure_analog_bits = reg_wdata[4:0];
      else if (reg_addr == OFS_HIGH_REF)
        st_nxt.high_ref_config_reg = reg_wdata & MASK_HIGH_REF;
      else if (reg_addr == OFS_MODE)
        st_nxt.converter_mode_reg = reg_wdata & MASK_MODE;
      else if (reg_addr == OFS_DIR)
        st_nxt.port4_direction_bits = reg_wdata[4:0]; // see R10 see R11
      else if (reg_addr == OFS_DATA)
        st_nxt.data_latch = reg_wdata[4:0];
    end
    // Converter end-of-conversion wins over software clear
    if (conv_eoc_set)
      st_nxt.converter_mode_reg[BIT_EOC] = 1'b1;
    if (reg_rd)
    begin
      if (reg_addr == OFS_PURE_ANALOG)
        st_nxt.rdata = {3'h0, st_r.port4_pure_analog_bits};
      else if (reg_addr == OFS_HIGH_REF)
        st_nxt.rdata = st_r.high_ref_config_reg;
      else if (reg_addr == OFS_MODE)
        st_nxt.rdata = st_r.converter_mode_reg;
      else if (reg_addr == OFS_DIR)
        st_nxt.rdata = {3'h0, st_r.port4_direction_bits};
      else if (reg_addr == OFS_DATA)
        st_nxt.rdata = {3'h0, din}; // see R2
    end
    st_nxt.chan = chs;
    st_nxt.chan_valid = gch && chs <= CH_MAX && !(chs == 3'h0 && ref_pin[0]); // see R7 see R8
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      st_r <= '0; // see R13
    else
      st_r <= st_nxt;
  end

  // ==========================================
  // Pin cells
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++)
    begin : g_pin
      pasm_pin_cell u_cell (
        .clock(clock),
        .resetn(resetn),
        .pure_analog(st_r.port4_pure_analog_bits[gi]),
        .analog_sel(sel_pin[gi]),
        .ref_sel(ref_pin[gi]),
        .dir(st_r.port4_direction_bits[gi]),
        .data(st_r.data_latch[gi]),
        .pad_in(pin_in[gi]),
        .pad_out(pin_out[gi]),
        .pad_oe(pin_oe[gi]),
        .analog_route(analog_route[gi]),
        .ref_route(ref_flag[gi]),
        .din(din[gi])
      );
    end
  endgenerate

  assign ext_high_ref_route = ref_flag[0];
  assign reg_rdata = st_r.rdata;
  assign conv_channel = st_r.chan;
  assign conv_channel_valid = st_r.chan_valid;
  assign converter_enable = st_r.converter_mode_reg[BIT_CONV_EN];
  assign conversion_start = st_r.converter_mode_reg[BIT_CONV_START];
  assign ref_select = st_r.high_ref_config_reg[1:0];

  // ==========================================
  // Checks
  AST_ONE_ROUTE: assert property (@(posedge clock) disable iff (!resetn) // see R1
    $onehot0(analog_route)) else $error("more than one analog pin");
  AST_PURE_NO_OE: assert property (@(posedge clock) disable iff (!resetn) // see R2
    st_r.port4_pure_analog_bits[0] |=> !pin_oe[0]) else $error("pure analog pin driven");
  AST_DIGITAL_OE: assert property (@(posedge clock) disable iff (!resetn) // see R3 see R5 see R11
    (!gch && !ref_pin[0] && !st_r.port4_pure_analog_bits[0] && st_r.port4_direction_bits[0])
    |=> pin_oe[0]) else $error("digital output not enabled");
  AST_NO_GCH: assert property (@(posedge clock) disable iff (!resetn) // see R5
    !gch |=> (analog_route == '0)) else $error("route without global enable");
  AST_SEL_ROUTE: assert property (@(posedge clock) disable iff (!resetn) // see R6 see R7
    (gch && chs == 3'h3) |=> analog_route[3] && !pin_oe[3]) else $error("selected pin");
  AST_REF_PIN0: assert property (@(posedge clock) disable iff (!resetn) // see R8
    ref_pin[0] |=> ext_high_ref_route && !analog_route[0] && !pin_oe[0])
    else $error("reference pin misuse");
  AST_PIN0_AIN: assert property (@(posedge clock) disable iff (!resetn) // see R12
    analog_route[0] |-> $past(gch) && $past(chs) == 3'h0) else $error("pin0 route");
  AST_READ_LAT: assert property (@(posedge clock) disable iff (!resetn) // see R13
    (reg_rd && reg_addr == OFS_MODE) |=> reg_rdata == $past(st_r.converter_mode_reg))
    else $error("mode read");
  AST_INPUT_MODE: assert property (@(posedge clock) disable iff (!resetn) // see R11
    (st_r.port4_direction_bits == '0) |=> (pin_oe == '0)) else $error("input pin driven");
  AST_PIN_OUT_DATA: assert property (@(posedge clock) disable iff (!resetn) // see R11
    pin_out == $past(st_r.data_latch)) else $error("pin drive value");
  AST_ISOLATED_READ: assert property (@(posedge clock) disable iff (!resetn) // see R2
    (st_r.port4_pure_analog_bits[0] && reg_rd && reg_addr == OFS_DATA) |=> !reg_rdata[0])
    else $error("isolated pin read");
  AST_BAD_CHANNEL: assert property (@(posedge clock) disable iff (!resetn) // see R7
    (chs > CH_MAX) |=> !conv_channel_valid) else $error("channel above five valid");
  AST_VALID_NEEDS_GCH: assert property (@(posedge clock) disable iff (!resetn) // see R5
    !gch |=> !conv_channel_valid) else $error("channel valid without enable");
  AST_REF_NEEDS_EN: assert property (@(posedge clock) disable iff (!resetn) // see R8
    !ref_pin[0] |=> !ext_high_ref_route) else $error("reference route without enable");

  // ==========================================
  // Multi-step checks
  // Reference held two cycles owns pin 0 fully
  sequence s_ref_held;
    ref_pin[0] ##1 ref_pin[0];
  endsequence

  sequence s_pin0_for_ref;
    ext_high_ref_route && !analog_route[0] && !pin_oe[0] && !din[0];
  endsequence

  // Selector pointing at a real pin
  sequence s_pick_pin;
    gch && chs < 3'(NPINS) && !ref_pin[0];
  endsequence

  sequence s_pin_taken;
    analog_route[$past(chs)] && !pin_oe[$past(chs)];
  endsequence

  // Reference claims channel 0
  sequence s_ref_on_ch0;
    gch && chs == 3'h0 && ref_pin[0];
  endsequence

  AST_REF_HELD: assert property (@(posedge clock) disable iff (!resetn) // see R8
    s_ref_held |-> s_pin0_for_ref) else $error("reference pin not isolated");
  AST_PICK_PIN: assert property (@(posedge clock) disable iff (!resetn) // see R6
    s_pick_pin |=> s_pin_taken) else $error("selected pin not analog");
  AST_REF_BLOCKS_CH0: assert property (@(posedge clock) disable iff (!resetn) // see R8
    s_ref_on_ch0 |=> !conv_channel_valid && !analog_route[0])
    else $error("channel 0 taken by reference");
endmodule : pasm_top

// ==== test/pasm_pad_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Pad side of the port
module pasm_pad_model
(
  // Design drive
  input wire logic [pasm_pkg::NPINS-1:0] pin_out,
  input wire logic [pasm_pkg::NPINS-1:0] pin_oe,
  // Board level and resulting pad
  input wire logic [pasm_pkg::NPINS-1:0] ext_lvl,
  output logic [pasm_pkg::NPINS-1:0] pin_in
);
  import pasm_pkg::*;
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
    end
  end
endmodule : pasm_pad_model

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import pasm_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [NPINS-1:0] pin_in, pin_out, pin_oe, analog_route;
  logic [NPINS-1:0] ext_lvl = 5'h15;
  logic ext_ref, ch_valid, conv_en, conv_go;
  logic [2:0] conv_ch;
  logic [1:0] ref_sel_o;
  logic eoc = 1'b0;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  pasm_top dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .analog_route(analog_route),
    .ext_high_ref_route(ext_ref), .conv_channel(conv_ch), .conv_channel_valid(ch_valid),
    .converter_enable(conv_en), .conversion_start(conv_go), .ref_select(ref_sel_o),
    .conv_eoc_set(eoc));
  pasm_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
  // ==========================================
  // Access tasks
  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic pins(input logic [4:0] oe, input logic [4:0] rt, input logic rf);
    @(posedge clock);
    #1 chk({3'h0, pin_oe}, {3'h0, oe});
    chk({3'h0, analog_route}, {3'h0, rt});
    chk({7'h00, ext_ref}, {7'h00, rf});
  endtask : pins
  // ==========================================
  // Timeout
  always @(posedge clock)
  begin
    cycles++;
    if (cycles >= 3000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // ==========================================
  // Tests
  initial
  begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    pins(5'h00, 5'h00, 1'b0);
    rd(OFS_PURE_ANALOG, 8'h00);
    rd(OFS_HIGH_REF, 8'h00);
    rd(OFS_MODE, 8'h00);
    rd(OFS_DATA, 8'h15);
    wr(OFS_PURE_ANALOG, 8'h01);
    repeat (3) @(posedge clock);
    rd(OFS_DATA, 8'h14);
    wr(OFS_DATA, 8'h1F);
    wr(OFS_DIR, 8'h01);
    pins(5'h00, 5'h00, 1'b0);
    wr(OFS_PURE_ANALOG, 8'h00);
    pins(5'h01, 5'h00, 1'b0);
    chk({7'h00, pin_out[0]}, 8'h01);
    chk({3'h0, pin_out}, 8'h1F);
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(OFS_MODE, 8'h90 | 8'(ch));
      pins((ch == 0) ? 5'h00 : 5'h01, (ch < 5) ? 5'(1 << ch) : 5'h00, 1'b0);
      chk({7'h00, ch_valid}, (ch <= 5) ? 8'h01 : 8'h00);
    end
    wr(OFS_MODE, 8'h10);
    pins(5'h01, 5'h00, 1'b0);
    wr(OFS_MODE, 8'h80);
    pins(5'h01, 5'h00, 1'b0);
    wr(OFS_MODE, 8'h90);
    wr(OFS_HIGH_REF, 8'hFF);
    pins(5'h00, 5'h00, 1'b1);
    rd(OFS_HIGH_REF, 8'h83);
    chk({6'h00, ref_sel_o}, 8'h03);
    wr(OFS_HIGH_REF, 8'h00);
    pins(5'h00, 5'h01, 1'b0);
    wr(OFS_MODE, 8'hDA);
    pins(5'h01, 5'h04, 1'b0);
    rd(OFS_MODE, 8'hD2);
    chk({5'h00, conv_ch}, 8'h02);
    chk({6'h00, conv_en, conv_go}, 8'h03);
    chk({7'h00, ch_valid}, 8'h01);
    // End of conversion lands before and with a write
    @(posedge clock);
    eoc <= 1'b1;
    wr(OFS_MODE, 8'h80);
    eoc <= 1'b0;
    rd(OFS_MODE, 8'hA0);
    pins(5'h01, 5'h00, 1'b0);
    // Reset in mid-run
    @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    pins(5'h00, 5'h00, 1'b0);
    rd(OFS_MODE, 8'h00);
    chk({3'h0, pin_out}, 8'h00);
    wr(8'h55, 8'hAA);
    rd(8'h55, 8'h00);
    stop_test();
  end
endmodule : tb_top
